// ### src/fdcp_top.sv
// Fault response, dither and counter capture of a two-output waveform timer.
// Assumes an AXI4-Lite master on aclk and event inputs synchronous to aclk.
//
// Implementation choices: the address map and the AXI4-Lite interface to the registers.
`include "fdcp_params.svh"
module fdcp_top (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write
  input wire fdcp_pkg::fdcp_addr_t s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire fdcp_pkg::fdcp_word_t s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire fdcp_pkg::fdcp_addr_t s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output fdcp_pkg::fdcp_word_t s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Event inputs
  input wire logic event_in_a,
  input wire logic event_in_b,
  // Waveforms and interrupt
  output logic waveform_out_a,
  output logic waveform_out_b,
  output logic irq
);
  import fdcp_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  logic [1:0] wave_q;
  logic run_q;
  logic [3:0] act_q [2];
  logic [1:0] cap_en_q;
  logic [1:0] dsel_q;
  logic [3:0] dstep_q;
  logic [11:0] dt_q [2];
  logic [11:0] ot_q [2];
  logic [1:0] int_en_q;
  logic [1:0] flags_q;
  logic [11:0] snap_q [2];
  logic cmd_busy_q;
  fdcp_state_e state_q, st_d, res_q, res_d;
  logic [12:0] cnt_q;
  logic [1:0] arm2_q, arm2_d, blank_q, blank_d, ev_q;
  logic lock7_q, lock7_d;
  logic [3:0] acc_q;
  logic pend_q;
  logic [1:0] cap_p1_q;
  logic [11:0] cap_v1_q [2];
  logic aw_full_q, w_full_q, bvalid_q, rvalid_q;
  fdcp_addr_t waddr_q;
  fdcp_word_t wdata_q, rdata_q;
  logic [3:0] wstrb_q;
  logic [1:0] bresp_q, rresp_q;
  logic out_a_q, out_b_q;

  logic [1:0] ev, rise, cap_req, sw_cap;
  logic wr_fire, restart, phase_end, in_ot, hold, ev7, off_all;
  logic [32:0] wr_old, rd_look;
  fdcp_word_t wr_val;
  logic [12:0] eff_len;
  fdcp_adj_e adj;
  logic [4:0] acc_sum;

  assign ev = {event_in_b, event_in_a};
  assign rise = ev & ~ev_q;

  ////////////////////////////////////////////////////////////////////////////
  // Helpers
  function automatic fdcp_state_e own_dt(input logic i);
    return i ? S_DTB : S_DTA;
  endfunction
  function automatic fdcp_state_e own_ot(input logic i);
    return i ? S_OTB : S_OTA;
  endfunction
  function automatic fdcp_state_e seq_next(input fdcp_state_e s);
    unique case (s)
      S_DTA: return S_OTA;
      S_OTA: return S_DTB;
      S_DTB: return S_OTB;
      S_OTB: return S_DTA;
      S_HALT: return S_HALT;
    endcase
  endfunction
  function automatic logic dith_hit(input logic [1:0] sel, input logic [1:0] ph);
    unique case (sel)
      `FDCP_DSEL_OTB: return ph == 2'h3;
      `FDCP_DSEL_OTAB: return ph[0];
      `FDCP_DSEL_DTB: return ph == 2'h2;
      `FDCP_DSEL_DTAB: return !ph[0];
    endcase
  endfunction
  // Dead-time choices (and the unused A on time in one ramp) are paid back by the next state, except in four ramp
  function automatic fdcp_adj_e dith_adj(input logic [1:0] wv, input logic [1:0] sel, input logic [1:0] ph);
    logic [1:0] pv;
    pv = ph - 2'h1;
    if (wv == `FDCP_WAVE_DUAL) return ADJ_NONE;
    if (dith_hit(sel, ph)) return ADJ_PLUS;
    if (dith_hit(sel, pv) && !pv[0] && wv != `FDCP_WAVE_FOUR) return ADJ_MINUS;
    if (wv == `FDCP_WAVE_ONE && sel == `FDCP_DSEL_OTAB && ph == 2'h2) return ADJ_MINUS;
    return ADJ_NONE;
  endfunction
  // Counter itself is never mapped; only the snapshots are
  function automatic logic [32:0] reg_read(input fdcp_addr_t a);
    unique case (a)
      `FDCP_REG_CTRL: return {1'b0, 29'h0, run_q, wave_q};
      `FDCP_REG_EVCTRL: return {1'b0, 22'h0, cap_en_q, act_q[1], act_q[0]};
      `FDCP_REG_DITHER: return {1'b0, 24'h0, dstep_q, 2'h0, dsel_q};
      `FDCP_REG_TIMEA: return {1'b0, 4'h0, ot_q[0], 4'h0, dt_q[0]};
      `FDCP_REG_TIMEB: return {1'b0, 4'h0, ot_q[1], 4'h0, dt_q[1]};
      `FDCP_REG_CMD: return {1'b0, 32'h0};
      `FDCP_REG_STATUS: return {1'b0, 27'h0, lock7_q, state_q, ~cmd_busy_q};
      `FDCP_REG_FLAGS: return {1'b0, 30'h0, flags_q};
      `FDCP_REG_INTEN: return {1'b0, 30'h0, int_en_q};
      `FDCP_REG_CAPAL: return {1'b0, 24'h0, snap_q[0][7:0]};
      `FDCP_REG_CAPAH: return {1'b0, 28'h0, snap_q[0][11:8]};
      `FDCP_REG_CAPBL: return {1'b0, 24'h0, snap_q[1][7:0]};
      `FDCP_REG_CAPBH: return {1'b0, 28'h0, snap_q[1][11:8]};
      default: return {1'b1, 32'h0};
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite slave: address and data taken in either order, write one cycle after both
  assign s_axi_awready = !aw_full_q && !bvalid_q;
  assign s_axi_wready = !w_full_q && !bvalid_q;
  assign s_axi_arready = !rvalid_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rresp = rresp_q;
  assign s_axi_rdata = rdata_q;
  assign wr_fire = aw_full_q && w_full_q && !bvalid_q;
  // A process, not an assign, so register changes behind an unchanged address are seen
  always_comb begin
    wr_old = reg_read(waddr_q);
    rd_look = reg_read(s_axi_araddr);
  end
  always_comb begin
    for (int b = 0; b < 4; b++) begin
      wr_val[b*8 +: 8] = wstrb_q[b] ? wdata_q[b*8 +: 8] : wr_old[b*8 +: 8];
    end
  end
  assign restart = wr_fire && waddr_q == `FDCP_REG_CMD && wr_val[`FDCP_CMD_RESTART];
  assign sw_cap = (wr_fire && waddr_q == `FDCP_REG_CMD) ? {wr_val[`FDCP_CMD_CAPB], wr_val[`FDCP_CMD_CAPA]} : 2'h0;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_q <= 1'b0;
      w_full_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= `FDCP_RESP_OKAY;
      waddr_q <= 8'h00;
      wdata_q <= 32'h0;
      wstrb_q <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_full_q <= 1'b1;
        waddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_full_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_full_q <= 1'b0;
        w_full_q <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q <= wr_old[32] ? `FDCP_RESP_SLVERR : `FDCP_RESP_OKAY;
      end else if (bvalid_q && s_axi_bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0;
      rresp_q <= `FDCP_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rvalid_q <= 1'b1;
      rdata_q <= rd_look[31:0];
      rresp_q <= rd_look[32] ? `FDCP_RESP_SLVERR : `FDCP_RESP_OKAY;
    end else if (rvalid_q && s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wave_q <= `FDCP_WAVE_ONE;
      run_q <= 1'b0;
      act_q[0] <= `FDCP_ACT_NONE;
      act_q[1] <= `FDCP_ACT_NONE;
      cap_en_q <= 2'h0;
      dsel_q <= `FDCP_DSEL_OTB;
      dstep_q <= 4'h0;
      dt_q[0] <= `FDCP_TIME_RST;
      dt_q[1] <= `FDCP_TIME_RST;
      ot_q[0] <= `FDCP_TIME_RST;
      ot_q[1] <= `FDCP_TIME_RST;
      int_en_q <= 2'h0;
    end else if (wr_fire) begin
      unique case (waddr_q)
        `FDCP_REG_CTRL: {run_q, wave_q} <= wr_val[`FDCP_CTRL_RUN:0];
        `FDCP_REG_EVCTRL: {cap_en_q, act_q[1], act_q[0]} <= wr_val[`FDCP_EV_CAPB:0];
        `FDCP_REG_DITHER: {dstep_q, dsel_q} <= {wr_val[7:4], wr_val[1:0]};
        `FDCP_REG_TIMEA: {ot_q[0], dt_q[0]} <= {wr_val[27:16], wr_val[11:0]};
        `FDCP_REG_TIMEB: {ot_q[1], dt_q[1]} <= {wr_val[27:16], wr_val[11:0]};
        `FDCP_REG_INTEN: int_en_q <= wr_val[1:0];
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Dither: one step per timer cycle, overflow stretches the selected state of the next cycle
  assign adj = pend_q ? dith_adj(wave_q, dsel_q, state_q[1:0]) : ADJ_NONE;
  always_comb begin
    eff_len = {1'b0, state_q[0] ? ot_q[state_q[1]] : dt_q[state_q[1]]};
    if (adj == ADJ_PLUS) eff_len = eff_len + 13'h1;
    else if (adj == ADJ_MINUS && eff_len != 13'h0) eff_len = eff_len - 13'h1;
  end
  assign acc_sum = {1'b0, acc_q} + {1'b0, dstep_q};

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      acc_q <= 4'h0;
      pend_q <= 1'b0;
    end else if (state_q == S_OTB && phase_end && run_q) begin
      acc_q <= acc_sum[3:0];
      pend_q <= acc_sum[4];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer with input actions; input A is applied last so it wins a conflict
  assign phase_end = cnt_q >= eff_len;
  assign in_ot = state_q == S_OTA || state_q == S_OTB;
  always_comb begin
    hold = 1'b0;
    ev7 = 1'b0;
    off_all = 1'b0;
    for (int i = 0; i < 2; i++) begin
      if (ev[i] && (act_q[i] == `FDCP_ACT_JUMP_WAIT || act_q[i] == `FDCP_ACT_EXEC_WAIT ||
          act_q[i] == `FDCP_ACT_NEXT_WAIT)) hold = 1'b1;
      if (ev[i] && act_q[i] == `FDCP_ACT_SW_WAIT) ev7 = 1'b1;
      if (ev[i] && (act_q[i] == `FDCP_ACT_ALL_OFF || act_q[i] == `FDCP_ACT_DEAD_ONLY)) off_all = 1'b1;
    end
  end

  always_comb begin
    st_d = state_q;
    res_d = res_q;
    arm2_d = arm2_q;
    lock7_d = lock7_q;
    if (!run_q) begin
      st_d = S_DTA;
      lock7_d = 1'b0;
      arm2_d = 2'h0;
    end else if (state_q == S_HALT) begin
      if (lock7_q) begin
        if (restart && !ev7) begin
          st_d = res_q;
          lock7_d = 1'b0;
        end
      end else if (!hold) begin
        st_d = res_q;
      end
    end else begin
      if (phase_end) st_d = seq_next(state_q);
      for (int j = 1; j >= 0; j--) begin
        unique case (act_q[j])
          `FDCP_ACT_JUMP_WAIT: if (ev[j] && (state_q == own_dt(j[0]) || state_q == own_ot(j[0]))) begin
            st_d = S_HALT;
            res_d = own_dt(!j[0]);
          end
          `FDCP_ACT_EXEC_WAIT: begin
            if (ev[j] && (state_q == own_dt(j[0]) || state_q == own_ot(j[0]))) begin
              st_d = own_dt(!j[0]);
              arm2_d[j] = 1'b1;
            end else if (arm2_q[j] && state_q == own_ot(!j[0]) && phase_end) begin
              arm2_d[j] = 1'b0;
              if (ev[j]) begin
                st_d = S_HALT;
                res_d = own_dt(j[0]);
              end
            end
          end
          `FDCP_ACT_EXEC_REPEAT: if (ev[j] && state_q == own_ot(!j[0]) && phase_end) st_d = own_dt(!j[0]);
          `FDCP_ACT_DEAD_ONLY: if (ev[j]) begin
            if (in_ot) st_d = seq_next(state_q);
            else if (phase_end) st_d = seq_next(seq_next(state_q));
          end
          `FDCP_ACT_NEXT_WAIT: if (ev[j] && (in_ot || phase_end)) begin
            st_d = S_HALT;
            res_d = in_ot ? seq_next(state_q) : seq_next(seq_next(state_q));
          end
          `FDCP_ACT_SW_WAIT: if (ev[j]) begin
            st_d = S_HALT;
            res_d = S_DTA;
            lock7_d = 1'b1;
          end
          `FDCP_ACT_EDGE_JUMP: if (rise[j] && state_q == own_ot(j[0])) st_d = own_dt(!j[0]);
          default: ;
        endcase
      end
    end
  end

  always_comb begin
    for (int k = 0; k < 2; k++) begin
      blank_d[k] = blank_q[k];
      if ((act_q[k] == `FDCP_ACT_EDGE_BLANK && rise[k]) || (act_q[k] == `FDCP_ACT_LEVEL_BLANK && ev[k]))
        blank_d[k] = 1'b1;
      if (st_d != own_ot(k[0]) || state_q != own_ot(k[0])) blank_d[k] = 1'b0;
      if (act_q[k] == `FDCP_ACT_LEVEL_BLANK && ev[k] && st_d == own_ot(k[0])) blank_d[k] = 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_q <= S_DTA;
      res_q <= S_DTA;
      cnt_q <= 13'h0;
      arm2_q <= 2'h0;
      lock7_q <= 1'b0;
      blank_q <= 2'h0;
      ev_q <= 2'h0;
      out_a_q <= 1'b0;
      out_b_q <= 1'b0;
    end else begin
      state_q <= st_d;
      res_q <= res_d;
      cnt_q <= (st_d != state_q || st_d == S_HALT || !run_q) ? 13'h0 : cnt_q + 13'h1;
      arm2_q <= arm2_d;
      lock7_q <= lock7_d;
      blank_q <= blank_d;
      ev_q <= ev;
      out_a_q <= st_d == S_OTA && !blank_d[0] && !off_all;
      out_b_q <= st_d == S_OTB && !blank_d[1] && !off_all;
    end
  end
  assign waveform_out_a = out_a_q;
  assign waveform_out_b = out_b_q;

  ////////////////////////////////////////////////////////////////////////////
  // Capture: request stage then snapshot; the event may also steer the sequencer
  assign cap_req = (cap_en_q & rise) | sw_cap;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cap_p1_q <= 2'h0;
      cap_v1_q[0] <= 12'h000;
      cap_v1_q[1] <= 12'h000;
      snap_q[0] <= 12'h000;
      snap_q[1] <= 12'h000;
      cmd_busy_q <= 1'b0;
      flags_q <= 2'h0;
    end else begin
      cap_p1_q <= cap_req;
      for (int c = 0; c < 2; c++) begin
        if (cap_req[c]) cap_v1_q[c] <= cnt_q[11:0];
        if (cap_p1_q[c]) snap_q[c] <= cap_v1_q[c];
      end
      if (|sw_cap) cmd_busy_q <= 1'b1;
      else if (|cap_p1_q) cmd_busy_q <= 1'b0;
      // Set beats a same-cycle write-one clear so no capture is lost
      flags_q <= (flags_q & ~((wr_fire && waddr_q == `FDCP_REG_FLAGS) ? wr_val[1:0] : 2'h0)) | cap_p1_q;
    end
  end
  assign irq = |(flags_q & int_en_q);

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  sequence s_swcap_a;
    wr_fire && waddr_q == `FDCP_REG_CMD && wr_val[`FDCP_CMD_CAPA];
  endsequence
  property p_off_all;
    @(posedge aclk) disable iff (!aresetn) off_all |=> !waveform_out_a && !waveform_out_b;
  endproperty
  a_off_all: assert property (p_off_all) else $error("outputs on during stop-all");
  property p_none_runs;
    @(posedge aclk) disable iff (!aresetn)
      act_q[0] == `FDCP_ACT_NONE && act_q[1] == `FDCP_ACT_NONE && state_q != S_HALT |=> state_q != S_HALT;
  endproperty
  a_none_runs: assert property (p_none_runs) else $error("halt with no input action");
  property p_jump_wait;
    @(posedge aclk) disable iff (!aresetn)
      run_q && act_q[0] == `FDCP_ACT_JUMP_WAIT && event_in_a && (state_q == S_DTA || state_q == S_OTA)
      |=> state_q == S_HALT && res_q == S_DTB;
  endproperty
  a_jump_wait: assert property (p_jump_wait) else $error("action 1 did not halt");
  property p_sw_wait;
    @(posedge aclk) disable iff (!aresetn) state_q == S_HALT && lock7_q && run_q && !restart |=> state_q == S_HALT;
  endproperty
  a_sw_wait: assert property (p_sw_wait) else $error("left halt without restart");
  property p_level_blank;
    @(posedge aclk) disable iff (!aresetn) act_q[0] == `FDCP_ACT_LEVEL_BLANK && event_in_a |=> !waveform_out_a;
  endproperty
  a_level_blank: assert property (p_level_blank) else $error("output A on during level blank");
  property p_swcap;
    @(posedge aclk) disable iff (!aresetn) s_swcap_a |=> cmd_busy_q ##1 (flags_q[0] && !cmd_busy_q);
  endproperty
  a_swcap: assert property (p_swcap) else $error("software capture not done in two cycles");
  property p_irq;
    @(posedge aclk) disable iff (!aresetn) $rose(flags_q[1]) && int_en_q[1] |-> irq;
  endproperty
  a_irq: assert property (p_irq) else $error("enabled trigger gave no interrupt");
  property p_dual;
    @(posedge aclk) disable iff (!aresetn) wave_q == `FDCP_WAVE_DUAL |-> adj == ADJ_NONE;
  endproperty
  a_dual: assert property (p_dual) else $error("dither active in dual slope");
endmodule

// ### inc/fdcp_params.svh
// Constants for the fault, dither and capture block: offsets, fields, resets, codes.
// Assumes byte addresses on an AXI4-Lite bus with 32-bit data.
// How it works
// - Action zero leaves outputs and sequence untouched
// - Action 1: own input halts, resumes other dead
// - Action 2: run other compare, halt, resume own
// - Action 3: repeat other compare while fault active
// - Action 4: both outputs off, counter keeps running
// - Action 5: only dead times while fault active
// - Action 6: end on time, halt, resume other
// - Action 7: halt until software restart command
// - Restart with input high halts again; start DTA
// - Action 8: edge ends on time, jump other dead
// - Action 9: edge blanks rest of on time
// - Action 10: level blanks own on time
// - Accumulate error; overflow inserts one clock
// - Select insert point among four options
// - Period additions per ramp mode follow table
// - No dithering in dual slope mode
// - Zero-addition choices lengthen state, shorten next
// - Counter readable only through two capture units
// - Capture by event or software; low then high
// - Capture-on-event bit enables event capture
// - Capture sets trigger flag; enable gates interrupt
// - Software strobe captures; wait for command done
`ifndef FDCP_PARAMS_SVH
`define FDCP_PARAMS_SVH
`define FDCP_REG_CTRL 8'h00
`define FDCP_REG_EVCTRL 8'h04
`define FDCP_REG_DITHER 8'h08
`define FDCP_REG_TIMEA 8'h0c
`define FDCP_REG_TIMEB 8'h10
`define FDCP_REG_CMD 8'h14
`define FDCP_REG_STATUS 8'h18
`define FDCP_REG_FLAGS 8'h1c
`define FDCP_REG_INTEN 8'h20
`define FDCP_REG_CAPAL 8'h24
`define FDCP_REG_CAPAH 8'h28
`define FDCP_REG_CAPBL 8'h2c
`define FDCP_REG_CAPBH 8'h30
`define FDCP_CMD_RESTART 0
`define FDCP_CMD_CAPA 1
`define FDCP_CMD_CAPB 2
`define FDCP_CTRL_RUN 2
`define FDCP_EV_CAPA 8
`define FDCP_EV_CAPB 9
`define FDCP_WAVE_ONE 2'h0
`define FDCP_WAVE_TWO 2'h1
`define FDCP_WAVE_FOUR 2'h2
`define FDCP_WAVE_DUAL 2'h3
`define FDCP_DSEL_OTB 2'h0
`define FDCP_DSEL_OTAB 2'h1
`define FDCP_DSEL_DTB 2'h2
`define FDCP_DSEL_DTAB 2'h3
`define FDCP_ACT_NONE 4'h0
`define FDCP_ACT_JUMP_WAIT 4'h1
`define FDCP_ACT_EXEC_WAIT 4'h2
`define FDCP_ACT_EXEC_REPEAT 4'h3
`define FDCP_ACT_ALL_OFF 4'h4
`define FDCP_ACT_DEAD_ONLY 4'h5
`define FDCP_ACT_NEXT_WAIT 4'h6
`define FDCP_ACT_SW_WAIT 4'h7
`define FDCP_ACT_EDGE_JUMP 4'h8
`define FDCP_ACT_EDGE_BLANK 4'h9
`define FDCP_ACT_LEVEL_BLANK 4'ha
`define FDCP_RESP_OKAY 2'h0
`define FDCP_RESP_SLVERR 2'h2
`define FDCP_TIME_RST 12'h000
`endif

// ### inc/fdcp_pkg.sv
// Types for the fault, dither and capture block.
// Assumes fdcp_params.svh supplies every numeric constant but the state and adjust encodings.
package fdcp_pkg;
  typedef logic [31:0] fdcp_word_t;
  typedef logic [7:0] fdcp_addr_t;
  typedef enum logic [2:0] {
    S_DTA = 3'b000,
    S_OTA = 3'b001,
    S_DTB = 3'b010,
    S_OTB = 3'b011,
    S_HALT = 3'b100
  } fdcp_state_e;
  typedef enum logic [1:0] {
    ADJ_NONE = 2'b00,
    ADJ_PLUS = 2'b01,
    ADJ_MINUS = 2'b10
  } fdcp_adj_e;
endpackage

// ### bench/fdcp_evsrc.sv
// Event system model driving the two fault and trigger inputs.
// Assumes requests from the bench on aclk; outputs are aclk-synchronous levels.
module fdcp_evsrc (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Requests from the bench
  input wire logic req_a,
  input wire logic req_b,
  // Event lines to the block
  output logic event_in_a,
  output logic event_in_b
);
  timeunit 1ns;
  timeprecision 1ps;
  ////////////////////////////////////////////////////////////////
  // Registered so that every edge the block derives is one clean step
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      event_in_a <= 1'b0;
      event_in_b <= 1'b0;
    end else begin
      event_in_a <= req_a;
      event_in_b <= req_b;
    end
  end
endmodule

// ### bench/fdcp_top_test.sv
// Self-checking bench for the fault, dither and capture block.
// Assumes the AXI4-Lite map in fdcp_params.svh and the event model beside it.
`include "fdcp_params.svh"
`define CHK(nm, ex, got) begin n_tests++; if ((got) !== (ex)) begin miscompares++; \
  $display("FAIL %s exp %0h got %0h", nm, ex, got); end end
module fdcp_top_test;
  timeunit 1ns;
  timeprecision 1ps;
  import fdcp_pkg::*;
  logic aclk = 1'b0, aresetn = 1'b0;
  fdcp_addr_t awaddr = 8'h00, araddr = 8'h00;
  fdcp_word_t wdata = 32'h0, rdata, d, hi;
  logic [3:0] wstrb = 4'h0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, wa, wb, irq, ev_a, ev_b;
  logic req_a = 1'b0, req_b = 1'b0;
  logic [1:0] bresp, rresp, rs;
  int miscompares = 0, n_tests = 0, cyc = 0, na, nb;
  int acts[5] = '{0, 4, 5, 10, 11};
  int xa[5] = '{10, 0, 0, 0, 10};
  int xb[5] = '{10, 0, 0, 10, 10};
  fdcp_top u_fdcp_top (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .event_in_a(ev_a),
    .event_in_b(ev_b), .waveform_out_a(wa), .waveform_out_b(wb), .irq(irq));
  fdcp_evsrc u_fdcp_evsrc (.aclk(aclk), .aresetn(aresetn), .req_a(req_a), .req_b(req_b),
    .event_in_a(ev_a), .event_in_b(ev_b));
  ////////////////////////////////////////////////////////////////
  initial begin
    forever #5 aclk = ~aclk;
  end
  // Hang guard: the whole sequence needs a little over a thousand cycles
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 20000) begin
      miscompares++;
      print_verdict();
    end
  end
  ////////////////////////////////////////////////////////////////
  task automatic axw(input fdcp_addr_t a, input fdcp_word_t v);
    logic ad, wd;
    ad = 1'b0;
    wd = 1'b0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= v;
    wstrb <= 4'hf;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(ad && wd)) begin
      @(posedge aclk);
      if (!ad && awready === 1'b1) begin
        ad = 1'b1;
        awvalid <= 1'b0;
      end
      if (!wd && wready === 1'b1) begin
        wd = 1'b1;
        wvalid <= 1'b0;
      end
    end
    while (bvalid !== 1'b1) @(posedge aclk);
    bready <= 1'b0;
  endtask
  task automatic axr(input fdcp_addr_t a, output fdcp_word_t v, output logic [1:0] r);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    while (rvalid !== 1'b1) @(posedge aclk);
    v = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask
  // Counts high cycles, by default over two full periods of 30 cycles
  task automatic cnt(input int n = 60);
    na = 0;
    nb = 0;
    repeat (n) begin
      @(posedge aclk);
      #1;
      na += (wa === 1'b1);
      nb += (wb === 1'b1);
    end
  endtask
  task automatic wait_done();
    do axr(`FDCP_REG_STATUS, d, rs); while (d[0] !== 1'b1);
  endtask
  task automatic print_verdict();
    $display("compares %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    axr(`FDCP_REG_CTRL, d, rs);
    `CHK("ctrl reset", 32'h0, d)
    axr(8'hfc, d, rs);
    `CHK("unmapped resp", `FDCP_RESP_SLVERR, rs)
    `CHK("unmapped data", 32'h0, d)
    // Long dead A so a resume read lands inside it
    axw(`FDCP_REG_TIMEA, 32'h0004000f);
    axw(`FDCP_REG_TIMEB, 32'h00040003);
    axw(`FDCP_REG_CTRL, 32'h4);
    repeat (10) @(posedge aclk);
    cnt();
    `CHK("base a", 10, na)
    `CHK("base b", 10, nb)
    axw(`FDCP_REG_CMD, 32'h2);
    wait_done();
    axr(`FDCP_REG_FLAGS, d, rs);
    `CHK("sw flag", 1'b1, d[0])
    `CHK("irq masked", 1'b0, irq)
    axr(`FDCP_REG_CAPAL, d, rs);
    axr(`FDCP_REG_CAPAH, hi, rs);
    `CHK("cap range", 1'b1, {hi[3:0], d[7:0]} < 12'd16)
    axw(`FDCP_REG_INTEN, 32'h3);
    #1;
    `CHK("irq on", 1'b1, irq)
    axw(`FDCP_REG_FLAGS, 32'h3);
    #1;
    `CHK("irq cleared", 1'b0, irq)
    foreach (acts[i]) begin
      // Same action on both inputs, so they never fight over the counter
      axw(`FDCP_REG_EVCTRL, acts[i] | (acts[i] << 4) | 32'h100);
      req_a <= 1'b1;
      repeat (20) @(posedge aclk);
      cnt();
      `CHK("act a", xa[i], na)
      `CHK("act b", xb[i], nb)
      req_a <= 1'b0;
      repeat (40) @(posedge aclk);
      axr(`FDCP_REG_FLAGS, d, rs);
      `CHK("ev flag", 1'b1, d[0])
      axw(`FDCP_REG_FLAGS, 32'h3);
    end
    axw(`FDCP_REG_EVCTRL, 32'h77);
    req_b <= 1'b1;
    repeat (20) @(posedge aclk);
    axr(`FDCP_REG_STATUS, d, rs);
    `CHK("sw halt", 5'h19, d[4:0])
    axw(`FDCP_REG_CMD, 32'h1);
    repeat (5) @(posedge aclk);
    axr(`FDCP_REG_STATUS, d, rs);
    `CHK("halt again", 4'hc, d[4:1])
    req_b <= 1'b0;
    cnt();
    `CHK("still off", 0, na + nb)
    axw(`FDCP_REG_CMD, 32'h1);
    axr(`FDCP_REG_STATUS, d, rs);
    `CHK("resume dta", 4'h0, d[4:1])
    cnt();
    `CHK("resumed", 20, na + nb)
    // Action 1 on input A: halt in A's half, resume at dead time B
    axw(`FDCP_REG_EVCTRL, 32'h1);
    req_a <= 1'b1;
    repeat (40) @(posedge aclk);
    cnt();
    `CHK("act1 off", 0, na + nb)
    axr(`FDCP_REG_STATUS, d, rs);
    `CHK("act1 halt", 3'h4, d[3:1])
    req_a <= 1'b0;
    cnt(20);
    `CHK("act1 a first", 0, na)
    `CHK("act1 b first", 5, nb)
    axw(`FDCP_REG_CMD, 32'h4);
    wait_done();
    axr(`FDCP_REG_FLAGS, d, rs);
    `CHK("sw flag b", 2'h2, d[1:0])
    `CHK("irq b", 1'b1, irq)
    axw(`FDCP_REG_FLAGS, 32'h3);
    // Dead time B grows by one and on time B pays it back, so the period stays 30
    axw(`FDCP_REG_DITHER, 32'hf2);
    repeat (70) @(posedge aclk);
    cnt();
    `CHK("dither a", 10, na)
    `CHK("dither b", 8, nb)
    axw(`FDCP_REG_CTRL, 32'h7);
    repeat (40) @(posedge aclk);
    cnt();
    `CHK("dual b", 10, nb)
    print_verdict();
  end
endmodule
